// ===== core/radio_regs_pkg.sv
// Package with register map, reset values and fixed codes of the test and status bank
package radio_regs_pkg;
  // Register addresses (6-bit header address)
  localparam logic [5:0] ADDR_RC_OSC_CFG_LOW   = 6'h28;
  localparam logic [5:0] ADDR_SYNTH_TEST       = 6'h29;
  localparam logic [5:0] ADDR_PRODUCTION_TEST  = 6'h2a;
  localparam logic [5:0] ADDR_GAIN_CTRL_TEST   = 6'h2b;
  localparam logic [5:0] ADDR_ANALOG_TEST_B    = 6'h2c;
  localparam logic [5:0] ADDR_ANALOG_TEST_A    = 6'h2d;
  localparam logic [5:0] ADDR_ANALOG_TEST_C    = 6'h2e;
  localparam logic [5:0] ADDR_CHIP_PART_ID     = 6'h30;
  localparam logic [5:0] ADDR_CHIP_REV_ID      = 6'h31;
  localparam logic [5:0] ADDR_FREQ_OFFSET_EST  = 6'h32;
  localparam logic [5:0] ADDR_LINK_QUALITY     = 6'h33;
  // Reset and wake values
  localparam logic [7:0] RST_RC_OSC_CFG_LOW    = 8'h00;
  localparam logic [7:0] RC_OSC_CFG_MASK       = 8'h7f;
  localparam logic [7:0] RST_SYNTH_TEST        = 8'h59;
  localparam logic [7:0] RST_PRODUCTION_TEST   = 8'h7f;
  localparam logic [7:0] TEMP_SENSOR_CODE      = 8'hbf;
  localparam logic [7:0] RST_GAIN_CTRL_TEST    = 8'h3f;
  localparam logic [7:0] RST_ANALOG_TEST_B     = 8'h88;
  localparam logic [7:0] RET_ANALOG_TEST_B     = 8'h81;
  localparam logic [7:0] RST_ANALOG_TEST_A     = 8'h31;
  localparam logic [7:0] RET_ANALOG_TEST_A     = 8'h35;
  localparam logic [7:0] RST_ANALOG_TEST_C     = 8'h0b;
  localparam int         OSC_SEL_CAL_BIT       = 1;
  // Identity codes, values arbitrary
  localparam logic [7:0] PART_ID_VALUE         = 8'h5a;
  localparam logic [7:0] REV_ID_VALUE          = 8'h03;
  // Link quality layout
  localparam int         CRC_MATCH_BIT         = 7;
  localparam int         LQ_SYMBOLS            = 64;
  // Serial frame
  localparam int         HDR_BITS              = 8;
  localparam int         FRAME_BITS            = 16;
  localparam int         RW_BIT                = 7;
endpackage

// ===== core/radio_test_and_status_regs.sv
// Test, calibration-support and status registers behind the serial register port
`timescale 1ns/10ps

module radio_test_and_status_regs
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Serial register port (mode 0, MSB first)
  input  wire logic       sel_n,
  input  wire logic       sclk,
  input  wire logic       mosi,
  output logic            miso,
  // Power and radio state
  input  wire logic       sleep_req,
  input  wire logic       radio_idle,
  input  wire logic       converter_retention,
  input  wire logic       amplitude_mod,
  // Demodulator results
  input  wire logic       offset_valid,
  input  wire logic [7:0] carrier_offset_value,
  input  wire logic       rx_start,
  input  wire logic       crc_done,
  input  wire logic       crc_match,
  input  wire logic       sync_found,
  input  wire logic       symbol_strobe,
  input  wire logic [6:0] link_quality_value,
  // Analog-side outputs
  output logic [7:0]      analog_test_b_int,
  output logic [7:0]      analog_test_a_int,
  output logic            osc_select_cal_enable,
  output logic            temp_sensor_en,
  output logic [6:0]      rc_osc_cfg
);

  typedef enum logic [2:0]
  {
    ST_HDR  = 3'b001,
    ST_DATA = 3'b010,
    ST_DONE = 3'b100
  } frame_t;

  // Pin synchronisers, registered with the state below
  logic [1:0] s_sel, s_clk, s_mosi;
  logic       sclk_d;
  wire rise = s_clk[1] & ~sclk_d;
  wire fall = ~s_clk[1] & sclk_d;
  wire frame_on = ~s_sel[1];

  // Register and frame state
  frame_t     state, next_state;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] hdr, next_hdr;
  logic [7:0] txreg, next_txreg;
  logic       next_miso;
  logic [7:0] rc_reg, synth_reg, production_test_reg, gain_reg, tb_reg, ta_reg, tc_reg;
  logic [7:0] next_rc, next_synth, next_production_test, next_gain, next_tb, next_ta, next_tc;
  logic [7:0] tb_int, ta_int, next_tb_int, next_ta_int;
  logic       was_sleep, next_was_sleep;
  logic [7:0] freq_reg, next_freq;
  logic       crc_flag, next_crc_flag;
  logic [6:0] lq_reg, next_lq;
  logic [6:0] sym_cnt, next_sym_cnt;
  logic       lq_run, next_lq_run;
  logic [7:0] rd_data;

  // Read mux, unused bits and unmapped addresses read zero
  always_comb
  begin
    case (hdr[5:0])
      radio_regs_pkg::ADDR_RC_OSC_CFG_LOW:  rd_data = rc_reg;
      radio_regs_pkg::ADDR_SYNTH_TEST:      rd_data = synth_reg;
      radio_regs_pkg::ADDR_PRODUCTION_TEST: rd_data = production_test_reg;
      radio_regs_pkg::ADDR_GAIN_CTRL_TEST:  rd_data = gain_reg;
      radio_regs_pkg::ADDR_ANALOG_TEST_B:   rd_data = tb_reg;
      radio_regs_pkg::ADDR_ANALOG_TEST_A:   rd_data = ta_reg;
      radio_regs_pkg::ADDR_ANALOG_TEST_C:   rd_data = tc_reg;
      radio_regs_pkg::ADDR_CHIP_PART_ID:    rd_data = radio_regs_pkg::PART_ID_VALUE;
      radio_regs_pkg::ADDR_CHIP_REV_ID:     rd_data = radio_regs_pkg::REV_ID_VALUE;
      radio_regs_pkg::ADDR_FREQ_OFFSET_EST: rd_data = freq_reg;
      radio_regs_pkg::ADDR_LINK_QUALITY:    rd_data = {crc_flag, lq_reg};
      default:                              rd_data = 8'h00;
    endcase
  end

  // Next-state logic for the serial frame and the register bank
  always_comb
  begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_shreg     = shreg;
    next_hdr       = hdr;
    next_txreg     = txreg;
    next_miso      = miso;
    next_rc        = rc_reg;
    next_synth     = synth_reg;
    next_production_test     = production_test_reg;
    next_gain      = gain_reg;
    next_tb        = tb_reg;
    next_ta        = ta_reg;
    next_tc        = tc_reg;
    next_tb_int    = tb_int;
    next_ta_int    = ta_int;
    next_was_sleep = sleep_req;
    if (!frame_on)
    begin
      next_state   = ST_HDR;
      next_bit_cnt = 5'h00;
      next_miso    = 1'b0;
    end
    else if (rise)
    begin
      next_shreg   = {shreg[6:0], s_mosi[1]};
      next_bit_cnt = bit_cnt + 5'h01;
      if (state == ST_HDR && bit_cnt == 5'(radio_regs_pkg::HDR_BITS - 1))
      begin
        next_hdr   = {shreg[6:0], s_mosi[1]};
        next_state = ST_DATA;
      end
      else if (state == ST_DATA && bit_cnt == 5'(radio_regs_pkg::FRAME_BITS - 1))
      begin
        next_state = ST_DONE;
        if (!hdr[radio_regs_pkg::RW_BIT])
        begin
          // Writes to read-only addresses fall through untouched
          case (hdr[5:0])
            radio_regs_pkg::ADDR_RC_OSC_CFG_LOW:
              next_rc = {shreg[6:0], s_mosi[1]} & radio_regs_pkg::RC_OSC_CFG_MASK;
            radio_regs_pkg::ADDR_SYNTH_TEST:      next_synth = {shreg[6:0], s_mosi[1]};
            radio_regs_pkg::ADDR_PRODUCTION_TEST: next_production_test = {shreg[6:0], s_mosi[1]};
            radio_regs_pkg::ADDR_GAIN_CTRL_TEST:  next_gain  = {shreg[6:0], s_mosi[1]};
            radio_regs_pkg::ADDR_ANALOG_TEST_B:
            begin
              next_tb     = {shreg[6:0], s_mosi[1]};
              next_tb_int = {shreg[6:0], s_mosi[1]};
            end
            radio_regs_pkg::ADDR_ANALOG_TEST_A:
            begin
              next_ta     = {shreg[6:0], s_mosi[1]};
              next_ta_int = {shreg[6:0], s_mosi[1]};
            end
            radio_regs_pkg::ADDR_ANALOG_TEST_C:   next_tc = {shreg[6:0], s_mosi[1]};
            default:                              next_tc = tc_reg;
          endcase
        end
      end
    end
    else if (fall)
    begin
      if (state == ST_DATA && bit_cnt == 5'(radio_regs_pkg::HDR_BITS))
      begin
        next_miso  = rd_data[7];
        next_txreg = {rd_data[6:0], 1'b0};
      end
      else if (state == ST_DATA)
      begin
        next_miso  = txreg[7];
        next_txreg = {txreg[6:0], 1'b0};
      end
    end
    // Sleep reloads reset values into the test registers; wake forces the analog copies
    if (sleep_req)
    begin
      next_rc    = radio_regs_pkg::RST_RC_OSC_CFG_LOW;
      next_synth = radio_regs_pkg::RST_SYNTH_TEST;
      next_production_test = radio_regs_pkg::RST_PRODUCTION_TEST;
      next_gain  = radio_regs_pkg::RST_GAIN_CTRL_TEST;
      next_tc    = radio_regs_pkg::RST_ANALOG_TEST_C;
      next_tb    = radio_regs_pkg::RST_ANALOG_TEST_B;
      next_ta    = radio_regs_pkg::RST_ANALOG_TEST_A;
    end
    if (was_sleep && !sleep_req)
    begin
      next_tb_int = converter_retention ? radio_regs_pkg::RET_ANALOG_TEST_B
                                        : radio_regs_pkg::RST_ANALOG_TEST_B;
      next_ta_int = converter_retention ? radio_regs_pkg::RET_ANALOG_TEST_A
                                        : radio_regs_pkg::RST_ANALOG_TEST_A;
    end
  end

  // Next-state logic for demodulator status
  always_comb
  begin
    next_freq     = freq_reg;
    next_crc_flag = crc_flag;
    next_lq       = lq_reg;
    next_sym_cnt  = sym_cnt;
    next_lq_run   = lq_run;
    if (amplitude_mod)
      next_freq = 8'h00;
    else if (offset_valid)
      next_freq = carrier_offset_value;
    if (crc_done)
      next_crc_flag = crc_match;
    if (rx_start)
      next_crc_flag = 1'b0;
    if (sync_found)
    begin
      next_lq_run  = 1'b1;
      next_sym_cnt = 7'h00;
    end
    else if (lq_run && symbol_strobe)
    begin
      next_sym_cnt = sym_cnt + 7'h01;
      if (sym_cnt == 7'(radio_regs_pkg::LQ_SYMBOLS - 1))
      begin
        next_lq_run = 1'b0;
        next_lq     = link_quality_value;
      end
    end
  end

  // State registers, pin synchronisers and registered outputs
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state     <= ST_HDR;
      bit_cnt   <= 5'h00;
      shreg     <= 8'h00;
      hdr       <= 8'h00;
      txreg     <= 8'h00;
      miso      <= 1'b0;
      rc_reg    <= radio_regs_pkg::RST_RC_OSC_CFG_LOW;
      synth_reg <= radio_regs_pkg::RST_SYNTH_TEST;
      production_test_reg <= radio_regs_pkg::RST_PRODUCTION_TEST;
      gain_reg  <= radio_regs_pkg::RST_GAIN_CTRL_TEST;
      tb_reg    <= radio_regs_pkg::RST_ANALOG_TEST_B;
      ta_reg    <= radio_regs_pkg::RST_ANALOG_TEST_A;
      tc_reg    <= radio_regs_pkg::RST_ANALOG_TEST_C;
      tb_int    <= radio_regs_pkg::RST_ANALOG_TEST_B;
      ta_int    <= radio_regs_pkg::RST_ANALOG_TEST_A;
      was_sleep <= 1'b0;
      freq_reg  <= 8'h00;
      crc_flag  <= 1'b0;
      lq_reg    <= 7'h00;
      sym_cnt   <= 7'h00;
      lq_run    <= 1'b0;
      s_sel     <= 2'h3;
      s_clk     <= 2'h0;
      s_mosi    <= 2'h0;
      sclk_d    <= 1'h0;
      analog_test_b_int     <= radio_regs_pkg::RST_ANALOG_TEST_B;
      analog_test_a_int     <= radio_regs_pkg::RST_ANALOG_TEST_A;
      osc_select_cal_enable <= radio_regs_pkg::RST_ANALOG_TEST_C[radio_regs_pkg::OSC_SEL_CAL_BIT];
      temp_sensor_en        <= 1'b0;
      rc_osc_cfg            <= radio_regs_pkg::RST_RC_OSC_CFG_LOW[6:0];
    end
    else
    begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      shreg     <= next_shreg;
      hdr       <= next_hdr;
      txreg     <= next_txreg;
      miso      <= next_miso;
      rc_reg    <= next_rc;
      synth_reg <= next_synth;
      production_test_reg <= next_production_test;
      gain_reg  <= next_gain;
      tb_reg    <= next_tb;
      ta_reg    <= next_ta;
      tc_reg    <= next_tc;
      tb_int    <= next_tb_int;
      ta_int    <= next_ta_int;
      was_sleep <= next_was_sleep;
      freq_reg  <= next_freq;
      crc_flag  <= next_crc_flag;
      lq_reg    <= next_lq;
      sym_cnt   <= next_sym_cnt;
      lq_run    <= next_lq_run;
      s_sel     <= {s_sel[0], sel_n};
      s_clk     <= {s_clk[0], sclk};
      s_mosi    <= {s_mosi[0], mosi};
      sclk_d    <= s_clk[1];
      analog_test_b_int     <= tb_int;
      analog_test_a_int     <= ta_int;
      osc_select_cal_enable <= tc_reg[radio_regs_pkg::OSC_SEL_CAL_BIT];
      temp_sensor_en        <= radio_idle &&
                               production_test_reg == radio_regs_pkg::TEMP_SENSOR_CODE;
      rc_osc_cfg            <= rc_reg[6:0];
    end
  end

  // Checks
  a_sleep_wipe: assert property (@(posedge clk) disable iff (sys_rst)
    sleep_req |=> production_test_reg == radio_regs_pkg::RST_PRODUCTION_TEST &&
                  synth_reg == radio_regs_pkg::RST_SYNTH_TEST)
    else $error("test registers kept over sleep");
  a_temp_sensor: assert property (@(posedge clk) disable iff (sys_rst)
    (radio_idle && production_test_reg == radio_regs_pkg::TEMP_SENSOR_CODE) |=> temp_sensor_en)
    else $error("temperature sensor not enabled");
  a_wake_force_b: assert property (@(posedge clk) disable iff (sys_rst)
    ($fell(sleep_req) && converter_retention) |=> ##1
      analog_test_b_int == radio_regs_pkg::RET_ANALOG_TEST_B)
    else $error("analog b not forced on wake");
  a_wake_read_b: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(sleep_req) |-> tb_reg == radio_regs_pkg::RST_ANALOG_TEST_B)
    else $error("analog b readback wrong after wake");
  a_wake_force_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($fell(sleep_req) && !converter_retention) |=> ##1
      analog_test_a_int == radio_regs_pkg::RST_ANALOG_TEST_A)
    else $error("analog a not forced on wake");
  a_wake_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(sleep_req) |-> ta_reg == radio_regs_pkg::RST_ANALOG_TEST_A)
    else $error("analog a readback wrong after wake");
  a_osc_cal_sleep: assert property (@(posedge clk) disable iff (sys_rst)
    sleep_req [*2] |=> osc_select_cal_enable)
    else $error("calibration enable not back to one after sleep");
  a_ask_zero: assert property (@(posedge clk) disable iff (sys_rst)
    amplitude_mod |=> freq_reg == 8'h00)
    else $error("offset not zero under amplitude keying");
  a_crc_clear: assert property (@(posedge clk) disable iff (sys_rst)
    rx_start |=> !crc_flag)
    else $error("match flag survived receive entry");
  c_wake_ret: cover property (@(posedge clk) $fell(sleep_req) && converter_retention);
  c_temp_on: cover property (@(posedge clk) temp_sensor_en);
  c_lq_done: cover property (@(posedge clk) lq_run ##1 !lq_run);
  c_frame_end: cover property (@(posedge clk) state == ST_DONE);

endmodule // radio_test_and_status_regs

// ===== test/radio_host_model.sv
// Host controller model driving the serial register port
`timescale 1ns/10ps
module radio_host_model
(
  // Clock
  input  wire logic       clk,
  // Serial register port
  input  wire logic       miso,
  output logic            sel_n,
  output logic            sclk,
  output logic            mosi,
  // Read results
  output logic            rd_valid,
  output logic [7:0]      rd_data
);
  // Idle port state
  initial
  begin
    sel_n    = 1'b1;
    sclk     = 1'b0;
    mosi     = 1'b0;
    rd_valid = 1'b0;
    rd_data  = 8'h00;
  end

  // One-cycle read strobe
  always @(posedge clk)
    if (rd_valid) rd_valid <= 1'b0;

  // One 16-bit frame, none for writes to 0x29 or 0x2b, sclk low 6 clk and high 5 clk per bit
  task automatic frame(input logic rd, input logic [5:0] addr, input logic [7:0] wdata);
    logic [15:0] tx;
    logic [7:0]  rx;
    tx = {rd, 1'b0, addr, wdata};
    rx = 8'h00;
    if (!rd && (addr == 6'h29 || addr == 6'h2b)) return;
    @(posedge clk);
    sel_n <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge clk);
      mosi <= tx[i];
      repeat (5) @(posedge clk);
      sclk <= 1'b1;
      if (i < 8) rx[i] = miso;
      repeat (5) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (6) @(posedge clk);
    sel_n <= 1'b1;
    mosi  <= ~mosi; // Released line shows no stale bit
    if (rd)
    begin
      rd_data  <= rx;
      rd_valid <= 1'b1;
    end
    repeat (5) @(posedge clk);
  endtask
endmodule // radio_host_model

// ===== test/radio_test_and_status_regs_tb.sv
// Self-checking bench for the test and status register bank
`timescale 1ns/10ps
module radio_test_and_status_regs_tb;
  logic       clk, sys_rst, sel_n, sclk, mosi, miso, sleep_req, radio_idle;
  logic       converter_retention, amplitude_mod, offset_valid, rx_start;
  logic       crc_done, crc_match, sync_found, symbol_strobe, rd_valid;
  logic       osc_select_cal_enable, temp_sensor_en;
  logic [7:0] carrier_offset_value, analog_test_b_int, analog_test_a_int, rd_data, v, w;
  logic [6:0] link_quality_value, rc_osc_cfg;
  int         failures, n_compared;
  logic [7:0] expq [$];
  logic [5:0] ra [10] = '{6'h28, 6'h29, 6'h2a, 6'h2b, 6'h2c, 6'h2d, 6'h2e, 6'h30, 6'h31, 6'h3f};
  logic [7:0] re [10] = '{8'h00, 8'h59, 8'h7f, 8'h3f, 8'h88, 8'h31, 8'h0b,
    radio_regs_pkg::PART_ID_VALUE, radio_regs_pkg::REV_ID_VALUE, 8'h00};

  radio_host_model host (.clk(clk), .miso(miso), .sel_n(sel_n), .sclk(sclk), .mosi(mosi),
    .rd_valid(rd_valid), .rd_data(rd_data));

  radio_test_and_status_regs dut (.clk(clk), .sys_rst(sys_rst), .sel_n(sel_n), .sclk(sclk),
    .mosi(mosi), .miso(miso), .sleep_req(sleep_req), .radio_idle(radio_idle),
    .converter_retention(converter_retention), .amplitude_mod(amplitude_mod),
    .offset_valid(offset_valid), .carrier_offset_value(carrier_offset_value),
    .rx_start(rx_start), .crc_done(crc_done), .crc_match(crc_match), .sync_found(sync_found),
    .symbol_strobe(symbol_strobe), .link_quality_value(link_quality_value),
    .analog_test_b_int(analog_test_b_int), .analog_test_a_int(analog_test_a_int),
    .osc_select_cal_enable(osc_select_cal_enable), .temp_sensor_en(temp_sensor_en),
    .rc_osc_cfg(rc_osc_cfg));

  // 50 ns clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic results();
    if (failures == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Note the expected byte, then run the read frame
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    expq.push_back(e);
    host.frame(1'b1, a, 8'h00);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.frame(1'b0, a, d);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Read results against the oldest note
  always @(posedge clk)
    if (rd_valid === 1'b1)
    begin
      if (expq.size() == 0)
      begin
        failures++;
        $display("wrong value at %0t: read with nothing expected", $time);
      end
      else chk(rd_data, expq.pop_front(), "read data");
    end

  // Hang guard
  initial
  begin
    #3000000;
    failures++;
    $display("wrong value at %0t: run did not finish", $time);
    results();
  end

  // Main sequence
  initial
  begin
    {sys_rst, sleep_req, radio_idle, converter_retention, amplitude_mod} = 5'h10;
    {offset_valid, rx_start, crc_done, crc_match, sync_found, symbol_strobe} = 6'h00;
    carrier_offset_value = 8'h00;
    link_quality_value   = 7'h00;
    failures   = 0;
    n_compared = 0;
    void'($urandom(51860));
    tick(10);
    sys_rst <= 1'b0;
    tick(2);
    chk({7'h00, osc_select_cal_enable}, 8'h01, "cal enable");
    chk({7'h00, temp_sensor_en}, 8'h00, "temp enable");
    chk(analog_test_b_int, 8'h88, "copy b");
    for (int i = 0; i < 10; i++) rd(ra[i], re[i]);
    for (int i = 0; i < 4; i++) wr(6'h30 + 6'(i), 8'($urandom));
    rd(6'h30, radio_regs_pkg::PART_ID_VALUE);
    rd(6'h31, radio_regs_pkg::REV_ID_VALUE);
    v = 8'($urandom) | 8'h80;
    wr(6'h28, v);
    rd(6'h28, v & 8'h7f);
    chk({1'b0, rc_osc_cfg}, v & 8'h7f, "rc cfg");
    // Temperature sensor only while idle
    radio_idle <= 1'b1;
    wr(6'h2a, 8'hbf);
    chk({7'h00, temp_sensor_en}, 8'h01, "temp on");
    radio_idle <= 1'b0;
    tick(3);
    chk({7'h00, temp_sensor_en}, 8'h00, "temp off idle");
    radio_idle <= 1'b1;
    wr(6'h2a, 8'h7f);
    chk({7'h00, temp_sensor_en}, 8'h00, "temp restored");
    v = 8'($urandom) & 8'hfd;
    wr(6'h2e, v);
    chk({7'h00, osc_select_cal_enable}, 8'h00, "cal off");
    rd(6'h2e, v);
    // Sleep and wake for both retention settings
    for (int r = 0; r < 2; r++)
    begin
      v = 8'($urandom) ^ 8'h88;
      w = 8'($urandom) ^ 8'h31;
      wr(6'h2c, v);
      wr(6'h2d, w);
      wr(6'h2a, 8'hbf);
      chk(analog_test_a_int, w, "copy a written");
      converter_retention <= r[0];
      sleep_req <= 1'b1;
      tick(8);
      sleep_req <= 1'b0;
      tick(4);
      chk(analog_test_b_int, r ? 8'h81 : 8'h88, "copy b wake");
      chk(analog_test_a_int, r ? 8'h35 : 8'h31, "copy a wake");
      chk({7'h00, osc_select_cal_enable}, 8'h01, "cal after wake");
      rd(6'h2c, 8'h88);
      rd(6'h2d, 8'h31);
      rd(6'h2a, 8'h7f);
      rd(6'h28, 8'h00);
    end
    // Offset estimate under both modulations
    for (int m = 0; m < 2; m++)
    begin
      v = 8'($urandom) | 8'h80;
      amplitude_mod <= m[0];
      carrier_offset_value <= v;
      offset_valid <= 1'b1;
      tick(1);
      offset_valid <= 1'b0;
      tick(2);
      rd(6'h32, m ? 8'h00 : v);
    end
    // Link quality after 64 symbols, CRC flag
    v = 8'($urandom);
    w = ~v;
    crc_match <= 1'b1;
    crc_done <= 1'b1;
    sync_found <= 1'b1;
    tick(1);
    {crc_done, sync_found} <= 2'b00;
    for (int i = 1; i <= 64; i++)
    begin
      tick(1);
      symbol_strobe <= 1'b1;
      link_quality_value <= (i == 64) ? v[6:0] : w[6:0];
      tick(1);
      symbol_strobe <= 1'b0;
    end
    tick(2);
    rd(6'h33, {1'b1, v[6:0]});
    {rx_start, crc_done} <= 2'b11;
    tick(1);
    {rx_start, crc_done} <= 2'b00;
    tick(2);
    rd(6'h33, {1'b0, v[6:0]});
    for (int k = 0; k < 100 && expq.size() > 0; k++) tick(1);
    if (expq.size() > 0)
    begin
      failures++;
      $display("wrong value at %0t: reads missing", $time);
    end
    results();
  end
endmodule // radio_test_and_status_regs_tb
